// ---- flash_cmd_pkg.sv ----
// Purpose: Shared constants and types for the flash command interpreter
// Assumes: 200 MHz core clock
// Notes:   Times are kept in ns; cycle counts derive from them
package flash_cmd_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ     = 200;
  localparam int T_DP_NS     = 3000;   // sleep_entry_delay, longest
  localparam int T_RES1_NS   = 3000;   // release_delay, least
  localparam int T_RES2_NS   = 5000;   // release_with_identifier_delay, least
  localparam int T_DP_CYC    = (T_DP_NS * CLK_MHZ) / 1000;
  localparam int T_RES1_CYC  = (T_RES1_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RES2_CYC  = (T_RES2_NS * CLK_MHZ + 999) / 1000;
  localparam int DLY_W       = 16;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [7:0] OP_RST_EN    = 8'h66;
  localparam logic [7:0] OP_RST       = 8'h99;
  localparam logic [7:0] OP_SLEEP     = 8'hB9;
  localparam logic [7:0] OP_WAKE      = 8'hAB;
  localparam logic [7:0] OP_MDID      = 8'h90;
  localparam logic [7:0] OP_STD_ID    = 8'h9F;
  localparam logic [7:0] OP_SFDP      = 8'h5A;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;

  // ****************************************
  // Addressing, byte positions, reset values
  // ****************************************
  localparam logic [7:0] SEC_REG1     = 8'h10;
  localparam logic [7:0] SEC_REG2     = 8'h20;
  localparam logic [7:0] SEC_REG3     = 8'h30;
  localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
  localparam logic [2:0] IDX_WAKE_ID  = 3'h3;
  localparam logic [2:0] IDX_SFDP_DAT = 3'h4;
  localparam logic [2:0] IDX_ERASE_END = 3'h4;
  localparam logic [1:0] CRB_XIP      = 2'b10;
  localparam logic [2:0] WRAP_RST     = 3'b111;
  localparam logic [7:0] PARAM_RST    = 8'h00;

  typedef enum logic [1:0] {PWR_AWAKE, PWR_ENTER, PWR_ASLEEP, PWR_WAKE} pwr_e;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_IGNORE, CMD_RST_EN, CMD_RST, CMD_SLEEP, CMD_WAKE,
    CMD_MDID, CMD_STD_ID, CMD_SFDP, CMD_SEC_ERASE, CMD_OTHER
  } cmd_e;

endpackage

// ---- spi_link_if.sv ----
// Purpose: Byte-level view of the serial link, front end to core
// Assumes: All signals on the core clock
// Notes:   Pulses last one clock
interface spi_link_if;
  logic       byte_valid;
  logic [7:0] rx_byte;
  logic [2:0] byte_idx;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic       sclk_fall;
  logic       cs_rise;
  logic       cs_fall;
  logic       cs_low;

  modport front (output byte_valid, rx_byte, byte_idx, bit_cnt, byte_cnt,
                 output sclk_fall, cs_rise, cs_fall, cs_low);
  modport core  (input byte_valid, rx_byte, byte_idx, bit_cnt, byte_cnt,
                 input sclk_fall, cs_rise, cs_fall, cs_low);
endinterface

// ---- spi_front.sv ----
// Purpose: Synchronise serial pins and assemble instruction bytes
// Assumes: Serial clock well below a quarter of clk
// Notes:   Byte count saturates at seven
module spi_front (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  spi_link_if.front lnk
);
  logic [2:0] sclk_sq;
  logic [2:0] cs_sq;
  logic [1:0] mosi_sq;
  logic [6:0] shift_q;
  logic [2:0] bit_q;
  logic [2:0] cnt_q;
  logic       rise;

  // ****************************************
  // Synchronisers
  // ****************************************
  // Chip select idles high so the first frame sees a clean fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sq <= 3'h0;
      cs_sq   <= 3'h7;
      mosi_sq <= 2'h0;
    end else begin
      sclk_sq <= {sclk_sq[1:0], sclk};
      cs_sq   <= {cs_sq[1:0], cs_n};
      mosi_sq <= {mosi_sq[0], mosi};
    end
  end

  assign rise          = sclk_sq[1] & ~sclk_sq[2] & ~cs_sq[1];
  assign lnk.sclk_fall = ~sclk_sq[1] & sclk_sq[2] & ~cs_sq[1];
  assign lnk.cs_rise   = cs_sq[1] & ~cs_sq[2];
  assign lnk.cs_fall   = ~cs_sq[1] & cs_sq[2];
  assign lnk.cs_low    = ~cs_sq[1];
  assign lnk.bit_cnt   = bit_q;
  assign lnk.byte_cnt  = cnt_q;

  // ****************************************
  // Byte assembly
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q        <= 7'h00;
      bit_q          <= 3'h0;
      cnt_q          <= 3'h0;
      lnk.byte_valid <= 1'b0;
      lnk.rx_byte    <= 8'h00;
      lnk.byte_idx   <= 3'h0;
    end else if (cs_sq[1]) begin
      bit_q          <= 3'h0;
      cnt_q          <= 3'h0;
      lnk.byte_valid <= 1'b0;
    end else if (rise) begin
      shift_q        <= {shift_q[5:0], mosi_sq[1]};
      bit_q          <= bit_q + 3'h1;
      lnk.byte_valid <= (bit_q == 3'h7);
      if (bit_q == 3'h7) begin
        lnk.rx_byte  <= {shift_q, mosi_sq[1]};
        lnk.byte_idx <= cnt_q;
        cnt_q        <= (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
      end
    end else begin
      lnk.byte_valid <= 1'b0;
    end
  end
endmodule

// ---- flash_cmd_core.sv ----
// Purpose: Reset, deep sleep, identifier and security erase commands
// Assumes: Pins from the host pass two flip-flops in spi_front
// Notes:   Array, program and status commands live in other blocks
// Overview of operation
// - Accepted reset aborts work, restores power-on state
// - Reset ignored in deep sleep until woken
// - Reset ignored during continuous read frames
// - Reset needs enable code then reset code
// - Any other command clears pending reset enable; commands ignored while busy leave it set
// - Sleep needs chip select high after bit eight
// - Enter sleep within entry delay after rise
// - Asleep, only the wake instruction is recognised
// - Power-up always in normal operation
// - Wake then wait release delay before commands
// - Identifier after three dummies, repeated, MSB first
// - Identifier wake uses the longer release delay
// - Wake or identifier ignored while busy
// - Maker/device bytes alternate, order by address
// - Standard read gives maker, type, capacity
// - Parameter table after address and eight dummies
// - Security erase needs latch and valid register
// - Erase runs after clean rise, busy set
// - Erase completion clears the write latch
// - Locked security registers ignore erase
// - Continuous read frame starts with address
// - Wrap enable bit set at power-on and reset
module flash_cmd_core #(
  parameter int         SEC_ERASE_TIME_US = 300,
  parameter logic [7:0] MAKER_ID          = 8'hA5,  // Arbitrary value
  parameter logic [7:0] DEVICE_ID         = 8'h3C,  // Arbitrary value
  parameter logic [7:0] MEM_TYPE_ID       = 8'h60,  // Arbitrary value
  parameter logic [7:0] CAPACITY_ID       = 8'h15   // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output wire logic       miso,
  output wire logic       miso_oe,
  input  wire logic [1:0] continuous_read_bits,
  input  wire logic       busy_ext,
  input  wire logic [2:0] otp_lock_bits,
  input  wire logic       wel_set,
  input  wire logic       wel_clr,
  input  wire logic       wrap_load,
  input  wire logic [2:0] wrap_value,
  input  wire logic       param_load,
  input  wire logic [7:0] param_value,
  output wire logic       write_latch_flag,
  output wire logic       write_in_progress,
  output wire logic       deep_sleep,
  output wire logic       soft_reset,
  output wire logic       xip_frame,
  output wire logic       erase_start,
  output wire logic [1:0] erase_sel,
  output wire logic [2:0] wrap_setting_bits,
  output wire logic [7:0] read_parameter_bits
);
  import flash_cmd_pkg::*;

  localparam int ERASE_CYC = SEC_ERASE_TIME_US * CLK_MHZ;
  localparam int DP_WIN    = T_DP_CYC;
  localparam int RES2_WIN  = T_RES2_CYC - 1;

  if (SEC_ERASE_TIME_US < 1 || T_DP_CYC < 1 || T_RES2_CYC >= (1 << DLY_W)) begin : g_chk
    $error("Timing parameters out of range");
  end

  spi_link_if lnk ();

  spi_front u_front (
    .clk   (clk),
    .rst_n (rst_n),
    .sclk  (sclk),
    .cs_n  (cs_n),
    .mosi  (mosi),
    .lnk   (lnk.front)
  );

  pwr_e              pwr_q;
  cmd_e              cmd_q;
  cmd_e              cmd_now;
  logic [DLY_W-1:0]  dly_q;
  logic              xip_q;
  logic              armed_q;
  logic              rst_ok_q;
  logic              soft_reset_q;
  logic              wel_q;
  logic              wip_q;
  logic              erase_done_q;
  logic              erase_start_q;
  logic [1:0]        erase_sel_q;
  logic [31:0]       erase_cnt_q;
  logic [2:0]        wrap_q;
  logic [7:0]        param_q;
  logic [23:0]       addr_q;
  logic [7:0]        tx_q;
  logic              miso_q;
  logic              loaded_q;
  logic              drive_q;
  logic              alt_q;
  logic [7:0]        ptr_q;
  logic              load_en;
  logic [7:0]        load_byte;
  logic              alt_d;
  logic [7:0]        ptr_d;
  logic              busy;
  logic              opcode_in;
  logic [1:0]        sel_now;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic cmd_e decode_op(input logic [7:0] op, input pwr_e pwr, input logic bsy);
    cmd_e c;
    c = CMD_IGNORE;
    if (pwr == PWR_ASLEEP) begin
      c = (op == OP_WAKE && !bsy) ? CMD_WAKE : CMD_IGNORE;
    end else if (pwr == PWR_AWAKE) begin
      case (op)
        OP_RST_EN:    c = CMD_RST_EN;
        OP_RST:       c = CMD_RST;
        OP_SLEEP:     c = CMD_SLEEP;
        OP_WAKE:      c = bsy ? CMD_IGNORE : CMD_WAKE;
        OP_MDID:      c = bsy ? CMD_IGNORE : CMD_MDID;
        OP_STD_ID:    c = bsy ? CMD_IGNORE : CMD_STD_ID;
        OP_SFDP:      c = bsy ? CMD_IGNORE : CMD_SFDP;
        OP_SEC_ERASE: c = bsy ? CMD_IGNORE : CMD_SEC_ERASE;
        default:      c = CMD_OTHER;
      endcase
    end
    return c;
  endfunction

  // Returns 1..3 for a valid register, 0 otherwise
  function automatic logic [1:0] sec_select(input logic [23:0] a);
    logic [1:0] s;
    s = 2'h0;
    if (a[23:16] == 8'h00) begin
      case (a[15:8])
        SEC_REG1: s = 2'h1;
        SEC_REG2: s = 2'h2;
        SEC_REG3: s = 2'h3;
        default:  s = 2'h0;
      endcase
    end
    return s;
  endfunction

  // Only the signature and the two bytes after it are populated; the rest reads erased
  function automatic logic [7:0] sfdp_rom(input logic [7:0] p);
    logic [7:0] b;
    case (p)
      8'h00:   b = 8'h53;
      8'h01:   b = 8'h46;
      8'h02:   b = 8'h44;
      8'h03:   b = 8'h50;
      8'h04:   b = 8'h06;
      8'h05:   b = 8'h01;
      default: b = 8'hFF;
    endcase
    return b;
  endfunction

  // Frame ended exactly on a byte boundary after n bytes
  function automatic logic clean_end(input logic [2:0] cnt, input logic [2:0] bits,
                                     input logic [2:0] n);
    return (cnt == n) && (bits == 3'h0);
  endfunction

  assign busy      = wip_q | busy_ext;
  assign opcode_in = lnk.byte_valid && lnk.byte_idx == 3'h0 && !xip_q;
  assign cmd_now   = opcode_in ? decode_op(lnk.rx_byte, pwr_q, busy) : cmd_q;
  assign sel_now   = sec_select(addr_q);

  // ****************************************
  // Frame decode
  // ****************************************
  // A continuous read frame carries no opcode, so nothing here decodes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xip_q <= 1'b0;
    end else if (lnk.cs_fall) begin
      xip_q <= (continuous_read_bits == CRB_XIP) && (pwr_q == PWR_AWAKE);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= CMD_NONE;
    end else if (lnk.cs_fall) begin
      cmd_q <= CMD_NONE;
    end else if (opcode_in) begin
      cmd_q <= cmd_now;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 24'h000000;
    end else if (lnk.byte_valid && lnk.byte_idx != 3'h0 && lnk.byte_idx <= IDX_ADDR_LAST) begin
      addr_q <= {addr_q[15:0], lnk.rx_byte};
    end
  end

  // ****************************************
  // Software reset pair
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q  <= 1'b0;
      rst_ok_q <= 1'b0;
    end else if (soft_reset_q) begin
      armed_q  <= 1'b0;
      rst_ok_q <= 1'b0;
    end else if (opcode_in && cmd_now != CMD_IGNORE) begin
      armed_q  <= (cmd_now == CMD_RST_EN);
      rst_ok_q <= (cmd_now == CMD_RST) && armed_q;
    end
  end

  // Only awake, non-continuous frames can decode the reset code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= lnk.cs_rise && cmd_q == CMD_RST && rst_ok_q && !xip_q
                      && clean_end(lnk.byte_cnt, lnk.bit_cnt, 3'h1);
    end
  end

  // ****************************************
  // Deep sleep
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= PWR_AWAKE;
      dly_q <= '0;
    end else begin
      case (pwr_q)
        PWR_AWAKE: begin
          if (lnk.cs_rise && cmd_q == CMD_SLEEP
              && clean_end(lnk.byte_cnt, lnk.bit_cnt, 3'h1)) begin
            pwr_q <= PWR_ENTER;
            dly_q <= DLY_W'(T_DP_CYC - 1);
          end
        end
        PWR_ENTER: begin
          if (dly_q == '0) begin
            pwr_q <= PWR_ASLEEP;
          end else begin
            dly_q <= dly_q - 1'b1;
          end
        end
        PWR_ASLEEP: begin
          if (lnk.cs_rise && cmd_q == CMD_WAKE) begin
            pwr_q <= PWR_WAKE;
            // Any byte clocked after the opcode means the longer delay applies
            dly_q <= (lnk.byte_cnt > 3'h1) ? DLY_W'(T_RES2_CYC - 1)
                                           : DLY_W'(T_RES1_CYC - 1);
          end
        end
        PWR_WAKE: begin
          if (dly_q == '0) begin
            pwr_q <= PWR_AWAKE;
          end else begin
            dly_q <= dly_q - 1'b1;
          end
        end
        default: begin
          pwr_q <= PWR_AWAKE;
        end
      endcase
    end
  end

  // ****************************************
  // Security register erase
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wip_q         <= 1'b0;
      erase_cnt_q   <= 32'h0;
      erase_done_q  <= 1'b0;
      erase_start_q <= 1'b0;
      erase_sel_q   <= 2'h0;
    end else begin
      erase_done_q  <= 1'b0;
      erase_start_q <= 1'b0;
      if (soft_reset_q) begin
        wip_q <= 1'b0;
      end else if (wip_q) begin
        if (erase_cnt_q == 32'h0) begin
          wip_q        <= 1'b0;
          erase_done_q <= 1'b1;
        end else begin
          erase_cnt_q <= erase_cnt_q - 32'h1;
        end
      end else if (lnk.cs_rise && cmd_q == CMD_SEC_ERASE && wel_q && sel_now != 2'h0
                   && clean_end(lnk.byte_cnt, lnk.bit_cnt, IDX_ERASE_END)
                   && !otp_lock_bits[sel_now - 2'h1]) begin
        wip_q         <= 1'b1;
        erase_cnt_q   <= 32'(ERASE_CYC - 1);
        erase_start_q <= 1'b1;
        erase_sel_q   <= sel_now;
      end
    end
  end

  // ****************************************
  // Volatile settings
  // ****************************************
  // A set arriving with wel_clr or erase completion wins so no enable is lost; a soft reset beats a set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_q <= 1'b0;
    end else if (wel_set && !soft_reset_q) begin
      wel_q <= 1'b1;
    end else if (erase_done_q || soft_reset_q || wel_clr) begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrap_q  <= WRAP_RST;
      param_q <= PARAM_RST;
    end else if (soft_reset_q) begin
      wrap_q  <= WRAP_RST;
      param_q <= PARAM_RST;
    end else begin
      if (wrap_load) begin
        wrap_q <= wrap_value;
      end
      if (param_load) begin
        param_q <= param_value;
      end
    end
  end

  // ****************************************
  // Response data
  // ****************************************
  always_comb begin
    load_en   = 1'b0;
    load_byte = 8'h00;
    alt_d     = alt_q;
    ptr_d     = ptr_q;
    case (cmd_now)
      CMD_STD_ID: begin
        load_en = 1'b1;
        case (lnk.byte_idx)
          3'h0:    load_byte = MAKER_ID;
          3'h1:    load_byte = MEM_TYPE_ID;
          3'h2:    load_byte = CAPACITY_ID;
          default: load_byte = 8'h00;
        endcase
      end
      CMD_WAKE: begin
        load_en   = lnk.byte_idx >= IDX_WAKE_ID;
        load_byte = DEVICE_ID;
      end
      CMD_MDID: begin
        load_en   = lnk.byte_idx >= IDX_ADDR_LAST;
        alt_d     = (lnk.byte_idx == IDX_ADDR_LAST) ? lnk.rx_byte[0] : alt_q;
        load_byte = alt_d ? DEVICE_ID : MAKER_ID;
        alt_d     = ~alt_d;
      end
      CMD_SFDP: begin
        load_en   = lnk.byte_idx >= IDX_SFDP_DAT;
        ptr_d     = (lnk.byte_idx == IDX_SFDP_DAT) ? addr_q[7:0] : ptr_q;
        load_byte = sfdp_rom(ptr_d);
        ptr_d     = ptr_d + 8'h01;
      end
      default: begin
        load_en = 1'b0;
      end
    endcase
  end

  // Shift out on sampled falling edges; pin enabled from first bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q     <= 8'h00;
      miso_q   <= 1'b0;
      loaded_q <= 1'b0;
      drive_q  <= 1'b0;
      alt_q    <= 1'b0;
      ptr_q    <= 8'h00;
    end else if (lnk.cs_fall || lnk.cs_rise) begin
      loaded_q <= 1'b0;
      drive_q  <= 1'b0;
    end else if (lnk.byte_valid && load_en) begin
      tx_q     <= load_byte;
      loaded_q <= 1'b1;
      alt_q    <= alt_d;
      ptr_q    <= ptr_d;
    end else if (lnk.sclk_fall && loaded_q) begin
      miso_q  <= tx_q[7];
      tx_q    <= {tx_q[6:0], 1'b0};
      drive_q <= 1'b1;
    end
  end

  assign miso                = miso_q;
  assign miso_oe             = drive_q & lnk.cs_low;
  assign write_latch_flag    = wel_q;
  assign write_in_progress   = wip_q;
  assign deep_sleep          = (pwr_q == PWR_ASLEEP);
  assign soft_reset          = soft_reset_q;
  assign xip_frame           = xip_q & lnk.cs_low;
  assign erase_start         = erase_start_q;
  assign erase_sel           = erase_sel_q;
  assign wrap_setting_bits   = wrap_q;
  assign read_parameter_bits = param_q;

  // ****************************************
  // Checks
  // ****************************************
  a_sleep_blocks_rst: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset_q |-> $past(pwr_q) == PWR_AWAKE)
    else $error("Reset taken while not awake");

  a_xip_blocks_rst: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset_q |-> !$past(xip_q))
    else $error("Reset taken in continuous read frame");

  a_reset_pair: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset_q |-> $past(cmd_q) == CMD_RST && $past(rst_ok_q, 1))
    else $error("Reset without enable pair");

  a_arm_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    opcode_in && cmd_now != CMD_IGNORE && cmd_now != CMD_RST_EN |=> !armed_q)
    else $error("Reset enable survived other command");

  a_sleep_entry: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pwr_q == PWR_ENTER) |-> ##[1:DP_WIN] pwr_q == PWR_ASLEEP)
    else $error("Sleep entry too slow");

  a_sleep_only_wake: assert property (@(posedge clk) disable iff (!rst_n)
    opcode_in && pwr_q == PWR_ASLEEP && lnk.rx_byte != OP_WAKE |=> cmd_q == CMD_IGNORE)
    else $error("Non-wake instruction recognised asleep");

  a_wake_delay: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pwr_q == PWR_WAKE) |-> pwr_q == PWR_WAKE [*2] ##[1:RES2_WIN] pwr_q == PWR_AWAKE)
    else $error("Wake delay wrong");

  a_erase_busy: assert property (@(posedge clk) disable iff (!rst_n)
    erase_start_q |-> wip_q && $past(wel_q))
    else $error("Erase started without latch or busy");

  a_wel_clears: assert property (@(posedge clk) disable iff (!rst_n)
    erase_done_q && !wel_set |=> !wel_q)
    else $error("Latch not cleared after erase");

  a_lock_honoured: assert property (@(posedge clk) disable iff (!rst_n)
    erase_start_q |-> !otp_lock_bits[erase_sel_q - 2'h1])
    else $error("Locked register erased");

  a_wrap_default: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset_q |=> wrap_q == WRAP_RST && param_q == PARAM_RST && !wel_q)
    else $error("Volatile settings not restored");
endmodule

// ---- flash_host_model.sv ----
// Purpose: Host serial controller model driving the flash link
// Assumes: Link clock period 64 ns, idle low between frames
// Notes:   Whole bytes only; data line toggles once released
module flash_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Frame driver
  // ****
  logic [7:0] txb [8];
  logic [7:0] rxb [8];
  logic       oe_seen;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Odd offset keeps link edges off core clock edges
  task automatic run(input int nb);
    oe_seen = 1'b0;
    #1.3 cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      for (int b = 7; b >= 0; b--) begin
        mosi = txb[i][b];
        #32 sclk = 1'b1;
        rxb[i][b] = miso;
        oe_seen |= miso_oe;
        #32 sclk = 1'b0;
      end
    end
    #32 cs_n = 1'b1;
    mosi = ~mosi;
    #48;
  endtask
endmodule

// ---- test_flash_cmd_core.sv ----
// Purpose: Self-checking bench for the flash command interpreter
// Assumes: Erase time shortened to 1 us
// Notes:   Expected bytes and flags come from a small bench model
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module test_flash_cmd_core;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_cmd_pkg::*;
  // ****
  // Model and stimulus
  // ****
  localparam logic [7:0] MK = 8'h5E;  // Arbitrary value
  localparam logic [7:0] DV = 8'h17;  // Arbitrary value
  localparam logic [7:0] MT = 8'h42;  // Arbitrary value
  localparam logic [7:0] CP = 8'h2B;  // Arbitrary value
  logic clk = 1'b0, rst_n = 1'b0, busy_ext = 1'b0, wel_set = 1'b0, wel_clr = 1'b0;
  logic wrap_load = 1'b0, param_load = 1'b0, ign = 1'b0, xf_seen = 1'b0;
  logic [1:0] crb = 2'b00, erase_sel;
  logic [2:0] otp = 3'h0, wrap_value = 3'h0, wrap_setting_bits, m_wrap = 3'h7;
  logic [7:0] param_value = 8'h00, read_parameter_bits, m_par = 8'h00;
  logic [31:0] r = 32'h7FCAFA47;
  logic sclk, cs_n, mosi, miso, miso_oe, write_latch_flag, write_in_progress;
  logic deep_sleep, soft_reset, xip_frame, erase_start, m_wel = 1'b0;
  int error_cnt = 0, n_tests = 0, sr_cnt = 0, es_cnt = 0, cyc = 0;
  logic [7:0] tbl [$] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01};
  flash_cmd_core #(.SEC_ERASE_TIME_US(1), .MAKER_ID(MK), .DEVICE_ID(DV),
    .MEM_TYPE_ID(MT), .CAPACITY_ID(CP)) uut (.clk(clk), .rst_n(rst_n),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .continuous_read_bits(crb), .busy_ext(busy_ext), .otp_lock_bits(otp),
    .wel_set(wel_set), .wel_clr(wel_clr), .wrap_load(wrap_load),
    .wrap_value(wrap_value), .param_load(param_load), .param_value(param_value),
    .write_latch_flag(write_latch_flag), .write_in_progress(write_in_progress),
    .deep_sleep(deep_sleep), .soft_reset(soft_reset), .xip_frame(xip_frame),
    .erase_start(erase_start), .erase_sel(erase_sel),
    .wrap_setting_bits(wrap_setting_bits), .read_parameter_bits(read_parameter_bits));
  flash_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Falling edge keeps the counts clear of the launching edge
  always @(negedge clk) begin
    sr_cnt += soft_reset;
    xf_seen |= xip_frame;
    es_cnt += erase_start;
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      stop_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [7:0] exp_b(input logic [7:0] op, input logic [7:0] a, input int k);
    int ix;
    ix = (a + k) % 256;
    case (op)
      8'h9F: return (k == 0) ? MK : (k == 1) ? MT : (k == 2) ? CP : 8'h00;
      8'h90: return ((k + a[0]) % 2 == 0) ? MK : DV;
      8'hAB: return DV;
      default: return (ix < 6) ? tbl[ix] : 8'hFF;
    endcase
  endfunction
  task automatic wc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ld();
    r = xs(r);
    wrap_load <= 1'b1;
    param_load <= 1'b1;
    wel_set <= 1'b1;
    wrap_value <= r[2:0];
    param_value <= r[10:3];
    wc(1);
    {wrap_load, param_load, wel_set} <= 3'h0;
    {m_wrap, m_par, m_wel} = {r[2:0], r[10:3], 1'b1};
    wc(1);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] m, input logic [7:0] a,
                     input int nb);
    int l;
    l = (op == 8'h9F) ? 1 : (op == 8'h5A) ? 5 : 4;
    for (int i = 0; i < 8; i++) host.txb[i] = 8'h00;
    {host.txb[0], host.txb[2], host.txb[3]} = {op, m, a};
    host.run(nb);
    if (ign) `CHK("ignored oe", 1'b0, host.oe_seen)
    else for (int k = l; k < nb; k++) `CHK("resp", exp_b(op, a, k - l), host.rxb[k])
  endtask
  task automatic chk_st(input int srs);
    wc(6);
    `CHK("soft resets", srs, sr_cnt)
    `CHK("wrap", m_wrap, wrap_setting_bits)
    `CHK("param", m_par, read_parameter_bits)
    `CHK("latch", m_wel, write_latch_flag)
  endtask
  initial begin
    wc(12);
    rst_n <= 1'b1;
    wc(4);
    `CHK("sleep", 1'b0, deep_sleep)
    chk_st(0);
    ld();
    `CHK("busy", 1'b0, write_in_progress)
    cmd(OP_RST_EN, 0, 0, 1);
    cmd(OP_RST, 0, 0, 1);
    {m_wrap, m_par, m_wel} = {3'h7, 8'h00, 1'b0};
    chk_st(1);
    ld();
    cmd(OP_RST_EN, 0, 0, 1);
    cmd(OP_STD_ID, 0, 0, 6);
    cmd(OP_RST, 0, 0, 1);
    chk_st(1);
    for (int a = 0; a < 2; a++) cmd(OP_MDID, 0, a[7:0], 8);
    cmd(OP_WAKE, 0, 0, 7);
    wc(1001);
    r = xs(r);
    cmd(OP_SFDP, 0, {5'h0, r[2:0]}, 8);
    wc(1);
    busy_ext <= 1'b1;
    ign = 1'b1;
    cmd(OP_STD_ID, 0, 0, 4);
    cmd(OP_WAKE, 0, 0, 6);
    wc(1);
    busy_ext <= 1'b0;
    ign = 1'b0;
    cmd(OP_SLEEP, 0, 0, 2);
    wc(700);
    `CHK("sleep", 1'b0, deep_sleep)
    cmd(OP_SLEEP, 0, 0, 1);
    wc(T_DP_CYC + 10);
    `CHK("sleep", 1'b1, deep_sleep)
    ld();
    cmd(OP_RST_EN, 0, 0, 1);
    cmd(OP_RST, 0, 0, 1);
    chk_st(1);
    ign = 1'b1;
    cmd(OP_STD_ID, 0, 0, 4);
    ign = 1'b0;
    cmd(OP_WAKE, 0, 0, 1);
    wc(5);
    `CHK("sleep", 1'b0, deep_sleep)
    wc(T_RES1_CYC + 1);
    cmd(OP_STD_ID, 0, 0, 4);
    cmd(OP_SEC_ERASE, SEC_REG2, 0, 4);
    wc(6);
    `CHK("erase", 4'hD, {es_cnt[0], erase_sel, write_in_progress})
    wc(210);
    m_wel = 1'b0;
    `CHK("busy", 1'b0, write_in_progress)
    chk_st(1);
    otp <= 3'h4;
    ld();
    cmd(OP_SEC_ERASE, SEC_REG3, 0, 4);
    wc(20);
    `CHK("locked", 32'h1, es_cnt)
    `CHK("xip", 1'b0, xf_seen)
    crb <= CRB_XIP;
    cmd(OP_RST_EN, 0, 0, 1);
    cmd(OP_RST, 0, 0, 1);
    wc(1);
    crb <= 2'b00;
    `CHK("xip", 1'b1, xf_seen)
    chk_st(1);
    cmd(OP_SLEEP, 0, 0, 1);
    wc(T_DP_CYC + 10);
    cmd(OP_WAKE, 0, 0, 5);
    wc(T_RES1_CYC + 1);
    ign = 1'b1;
    cmd(OP_STD_ID, 0, 0, 4);
    ign = 1'b0;
    wc(T_RES2_CYC - T_RES1_CYC);
    cmd(OP_STD_ID, 0, 0, 4);
    stop_test();
  end
  task automatic stop_test();
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
endmodule
